/* inc/pin_mux_defs.svh */
// register offsets, field positions, reset values and fixed codes of the pin function mux
// assumes: included by bare name; apb data 32 bits, one register per aligned word
//
// Operation
// R1 - names ending in _n are asserted low; everything else asserted high.
// R2 - reference clock select: 0 means 100 MHz, 1 means 125 MHz.
// R3 - core and transceiver clocks come from the reference clock via on-chip plls.
// R4 - each gpio pin individually a plain input or output, or its alternate function.
// R5 - gpio 0 alternate: output driving active-low reset of downstream port 2.
// R6 - gpio 1 alternate: output driving active-low reset of downstream port 4.
// R7 - gpio 2, 3, 4 alternate: active-low expander interrupt inputs 0, 1, 2.
// R8 - master bus eeprom address built from master address straps bits 4 to 1.
// R9 - slave bus address built from slave address straps bits 5 and 3 to 1.
// R10 - bus clock and data lines on both ports are bidirectional.
// R11 - straps captured at fundamental reset release; fixed address bits added.
// R12 - asserted expander interrupt triggers a master bus read of hot-plug inputs.
// R13 - alternate function dictates pin direction, overriding the gpio direction setting.
// R14 - after reset every gpio is an input with alternate function off.
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

`define ADDR_GPIO_DIR   8'h00
`define ADDR_GPIO_OUT   8'h04
`define ADDR_GPIO_ALT   8'h08
`define ADDR_GPIO_IN    8'h0C
`define ADDR_STRAP      8'h10
`define ADDR_EXP_STAT   8'h14
`define ADDR_PORT_RST   8'h18

`define GPIO_COUNT      11
`define ALT_MASK        11'h01F
`define GPIO_DIR_RST    11'h000
`define GPIO_OUT_RST    11'h000
`define GPIO_ALT_RST    11'h000
`define PORT_RST_RST    2'h0

`define PIN_PORT2_RST   0
`define PIN_PORT4_RST   1
`define PIN_EXP_IRQ0    2
`define EXP_IRQ_COUNT   3

`define SLV_ADDR_B7     1'h1
`define SLV_ADDR_B6     1'h1
`define SLV_ADDR_B4     1'h0
`define MST_ADDR_B7     1'h1
`define MST_ADDR_B6     1'h0
`define MST_ADDR_B5     1'h1

`define REFSEL_100      1'h0
`define REFSEL_125      1'h1
`define PLL_FBDIV_100   6'h19
`define PLL_FBDIV_125   6'h14

`define STRAP_SLV_LSB   0
`define STRAP_MST_LSB   8
`define STRAP_REFSEL    16
`define EXP_PENDING     3

`endif

/* inc/pin_mux_pkg.sv */
// types shared by the pin function mux and its expander request helper
// assumes: nothing beyond the compiler
package pin_mux_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } apb_state_e;

endpackage

/* hdl/expander_read_request.sv */
// raises a hot-plug input read request towards the master bus engine
// assumes: interrupt levels already gated by pin function; engine acks with one pulse
`timescale 1ns/1ps
`default_nettype none
module expander_read_request
    import pin_mux_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // expander side, active low levels
    input  wire logic [2:0] irq_n,
    // master bus engine side
    input  wire logic       read_ack,
    output var  logic       read_req_r
);

    logic read_req_nxt;
    logic any_irq;

    always_comb
    begin
        any_irq = ~&irq_n;
        // an interrupt still low at the ack restarts the read; set wins over clear
        read_req_nxt = read_req_r;
        if (read_ack)
            read_req_nxt = 1'b0;
        if (any_irq)
            read_req_nxt = 1'b1; // R12
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            read_req_r <= 1'b0;
        else
            read_req_r <= read_req_nxt;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    irq_starts_read_a: assert property (any_irq |=> read_req_r) // R12
        else $error("expander interrupt did not raise a read request");
    req_holds_a: assert property (read_req_r && !read_ack |=> read_req_r) // R12
        else $error("read request dropped before ack");

endmodule
`default_nettype wire

/* hdl/switch_pin_function_mux.sv */
// gpio alternate function mux, address straps, reference select and bus pin drivers
// assumes: all inputs synchronous to clock; apb master per amba rules; the pll itself
// and the bus protocol engines sit outside and use the configuration driven here
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"
module switch_pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int GPIO_W = `GPIO_COUNT
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // register bus
    input  wire apb_req_s          apb_in,
    output var  logic [31:0]       prdata_r,
    output var  logic              pready_r,
    output var  logic              pslverr_r,
    // system pins and straps
    input  wire logic              fundamental_reset_n,
    input  wire logic              ref_clock_freq_select,
    input  wire logic [3:0]        master_bus_addr_strap,
    input  wire logic [3:0]        slave_bus_addr_strap,
    // configuration towards pll and bus engines
    output var  logic [5:0]        pll_fbdiv_r,
    output var  logic [6:0]        master_bus_addr_r,
    output var  logic [6:0]        slave_bus_addr_r,
    // general purpose pins
    input  wire logic [GPIO_W-1:0] gpio_in,
    output var  logic [GPIO_W-1:0] gpio_out_r,
    output var  logic [GPIO_W-1:0] gpio_oe_n_r,
    // expander interrupts after the mux and read request
    output var  logic [2:0]        expander_irq_n_r,
    output var  logic              expander_read_req_r,
    input  wire logic              expander_read_ack,
    // bus line drive requests from the engines, high pulls the line low
    input  wire logic              master_clock_pull,
    input  wire logic              master_data_pull,
    input  wire logic              slave_clock_pull,
    input  wire logic              slave_data_pull,
    // bus lines, open drain
    input  wire logic              master_bus_clock_line_in,
    output var  logic              master_bus_clock_line_out,
    output var  logic              master_bus_clock_line_oe_n,
    input  wire logic              master_bus_data_line_in,
    output var  logic              master_bus_data_line_out,
    output var  logic              master_bus_data_line_oe_n,
    input  wire logic              slave_bus_clock_line_in,
    output var  logic              slave_bus_clock_line_out,
    output var  logic              slave_bus_clock_line_oe_n,
    input  wire logic              slave_bus_data_line_in,
    output var  logic              slave_bus_data_line_out,
    output var  logic              slave_bus_data_line_oe_n,
    // sampled bus line levels back to the engines
    output var  logic [3:0]        bus_line_level_r
);

    localparam logic [GPIO_W-1:0] ALT_MASK = GPIO_W'(`ALT_MASK);

    function automatic logic [31:0] zext(input logic [GPIO_W-1:0] v);
        zext = 32'(v);
    endfunction

    // configuration registers
    logic [GPIO_W-1:0] dir_r, dir_nxt;
    logic [GPIO_W-1:0] dout_r, dout_nxt;
    logic [GPIO_W-1:0] alt_r, alt_nxt;
    logic [1:0]        port_rst_r, port_rst_nxt;
    logic [GPIO_W-1:0] gpio_in_r;

    // apb slave
    apb_state_e        state_r, state_nxt;
    logic [31:0]       prdata_nxt;
    logic              pready_nxt;
    logic              pslverr_nxt;
    logic              hit;
    logic [31:0]       rd_word;
    logic              wr_commit;

    // straps
    logic              fund_prev_r;
    logic              capture;
    logic [5:0]        pll_fbdiv_nxt;
    logic [6:0]        master_addr_nxt;
    logic [6:0]        slave_addr_nxt;
    logic              refsel_r, refsel_nxt;

    // pins
    logic [GPIO_W-1:0] gpio_out_nxt;
    logic [GPIO_W-1:0] gpio_oe_n_nxt;
    logic [2:0]        irq_n_nxt;
    logic              cfg_rst;

    // fundamental reset clears the pin configuration as well as rst does
    assign cfg_rst = rst | ~fundamental_reset_n;

    always_comb
    begin
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (apb_in.paddr)
            `ADDR_GPIO_DIR: rd_word = zext(dir_r);
            `ADDR_GPIO_OUT: rd_word = zext(dout_r);
            `ADDR_GPIO_ALT: rd_word = zext(alt_r);
            `ADDR_GPIO_IN:  rd_word = zext(gpio_in_r);
            `ADDR_STRAP:
            begin
                rd_word[`STRAP_SLV_LSB +: 7] = slave_bus_addr_r;
                rd_word[`STRAP_MST_LSB +: 7] = master_bus_addr_r;
                rd_word[`STRAP_REFSEL] = refsel_r;
            end
            `ADDR_EXP_STAT:
            begin
                rd_word[2:0] = ~expander_irq_n_r;
                rd_word[`EXP_PENDING] = expander_read_req_r;
            end
            `ADDR_PORT_RST: rd_word[1:0] = port_rst_r;
            default:        hit = 1'b0;
        endcase
    end

    // pready rises one cycle into the access phase; the write lands on the edge
    // that samples pready, so a write and its readback never overlap
    always_comb
    begin
        state_nxt = state_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        wr_commit = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (apb_in.psel && apb_in.penable)
                begin
                    state_nxt = ST_DONE;
                    pready_nxt = 1'b1;
                    pslverr_nxt = ~hit;
                    prdata_nxt = (apb_in.pwrite || !hit) ? 32'h0000_0000 : rd_word;
                end
            end
            ST_DONE:
            begin
                state_nxt = ST_IDLE;
                wr_commit = apb_in.pwrite & hit & ~pslverr_r;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_comb
    begin
        dir_nxt = dir_r;
        dout_nxt = dout_r;
        alt_nxt = alt_r;
        port_rst_nxt = port_rst_r;
        if (wr_commit)
        begin
            case (apb_in.paddr)
                `ADDR_GPIO_DIR: dir_nxt = apb_in.pwdata[GPIO_W-1:0]; // R4
                `ADDR_GPIO_OUT: dout_nxt = apb_in.pwdata[GPIO_W-1:0];
                // pins without an alternate function keep the select bit at zero
                `ADDR_GPIO_ALT: alt_nxt = apb_in.pwdata[GPIO_W-1:0] & ALT_MASK; // R4
                `ADDR_PORT_RST: port_rst_nxt = apb_in.pwdata[1:0];
                default:        port_rst_nxt = port_rst_r;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (cfg_rst)
        begin
            dir_r <= `GPIO_DIR_RST; // R14
            dout_r <= `GPIO_OUT_RST;
            alt_r <= `GPIO_ALT_RST; // R14
            port_rst_r <= `PORT_RST_RST;
        end
        else
        begin
            dir_r <= dir_nxt;
            dout_r <= dout_nxt;
            alt_r <= alt_nxt;
            port_rst_r <= port_rst_nxt;
        end
    end

    // strap capture on the first cycle the fundamental reset reads released
    always_comb
    begin
        capture = fundamental_reset_n & ~fund_prev_r; // R11
        refsel_nxt = refsel_r;
        pll_fbdiv_nxt = pll_fbdiv_r;
        master_addr_nxt = master_bus_addr_r;
        slave_addr_nxt = slave_bus_addr_r;
        if (capture)
        begin
            refsel_nxt = ref_clock_freq_select;
            // feedback divider keeps the pll output fixed for either reference
            pll_fbdiv_nxt = (ref_clock_freq_select == `REFSEL_125) ? `PLL_FBDIV_125 : `PLL_FBDIV_100; // R2 R3
            master_addr_nxt = {`MST_ADDR_B7, `MST_ADDR_B6, `MST_ADDR_B5, master_bus_addr_strap}; // R8 R11
            // strap index 3 carries address bit 5, indices 2..0 carry bits 3..1
            slave_addr_nxt = {`SLV_ADDR_B7, `SLV_ADDR_B6, slave_bus_addr_strap[3], `SLV_ADDR_B4,
                              slave_bus_addr_strap[2:0]}; // R9 R11
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fund_prev_r <= 1'b0;
            refsel_r <= `REFSEL_100;
            pll_fbdiv_r <= `PLL_FBDIV_100;
            master_bus_addr_r <= 7'h00;
            slave_bus_addr_r <= 7'h00;
        end
        else
        begin
            fund_prev_r <= fundamental_reset_n;
            refsel_r <= refsel_nxt;
            pll_fbdiv_r <= pll_fbdiv_nxt;
            master_bus_addr_r <= master_addr_nxt;
            slave_bus_addr_r <= slave_addr_nxt;
        end
    end

    // pin drivers: alternate function type overrides the gpio direction
    always_comb
    begin
        gpio_out_nxt = dout_r;
        gpio_oe_n_nxt = ~dir_r; // R4
        for (int i = 0; i < GPIO_W; i++)
        begin
            if (alt_r[i])
                gpio_oe_n_nxt[i] = 1'b1; // R13
        end
        // port resets follow software; the fundamental reset drives them low for one cycle, then clears alt_r
        if (alt_r[`PIN_PORT2_RST])
        begin
            gpio_out_nxt[`PIN_PORT2_RST] = ~(port_rst_r[0] | ~fundamental_reset_n); // R1 R5
            gpio_oe_n_nxt[`PIN_PORT2_RST] = 1'b0; // R13
        end
        if (alt_r[`PIN_PORT4_RST])
        begin
            gpio_out_nxt[`PIN_PORT4_RST] = ~(port_rst_r[1] | ~fundamental_reset_n); // R1 R6
            gpio_oe_n_nxt[`PIN_PORT4_RST] = 1'b0; // R13
        end
        for (int k = 0; k < `EXP_IRQ_COUNT; k++)
        begin
            // a pin not in its alternate role reads as a deasserted interrupt
            irq_n_nxt[k] = alt_r[`PIN_EXP_IRQ0 + k] ? gpio_in[`PIN_EXP_IRQ0 + k] : 1'b1; // R1 R7
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gpio_out_r <= `GPIO_OUT_RST;
            gpio_oe_n_r <= '1;
            gpio_in_r <= '0;
            expander_irq_n_r <= 3'h7;
            master_bus_clock_line_oe_n <= 1'b1;
            master_bus_data_line_oe_n <= 1'b1;
            slave_bus_clock_line_oe_n <= 1'b1;
            slave_bus_data_line_oe_n <= 1'b1;
            master_bus_clock_line_out <= 1'b0;
            master_bus_data_line_out <= 1'b0;
            slave_bus_clock_line_out <= 1'b0;
            slave_bus_data_line_out <= 1'b0;
            bus_line_level_r <= 4'hF;
        end
        else
        begin
            gpio_out_r <= gpio_out_nxt;
            gpio_oe_n_r <= gpio_oe_n_nxt;
            gpio_in_r <= gpio_in;
            expander_irq_n_r <= irq_n_nxt;
            master_bus_clock_line_oe_n <= ~master_clock_pull; // R10
            master_bus_data_line_oe_n <= ~master_data_pull; // R10
            slave_bus_clock_line_oe_n <= ~slave_clock_pull; // R10
            slave_bus_data_line_oe_n <= ~slave_data_pull; // R10
            // open drain: the line is only ever pulled low, released otherwise
            master_bus_clock_line_out <= 1'b0;
            master_bus_data_line_out <= 1'b0;
            slave_bus_clock_line_out <= 1'b0;
            slave_bus_data_line_out <= 1'b0;
            bus_line_level_r <= {slave_bus_data_line_in, slave_bus_clock_line_in,
                                 master_bus_data_line_in, master_bus_clock_line_in}; // R10
        end
    end

    expander_read_request u_exp_req
    (
        .clock      (clock),
        .rst        (rst),
        .irq_n      (expander_irq_n_r),
        .read_ack   (expander_read_ack),
        .read_req_r (expander_read_req_r)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    alt_dir_in_a: assert property (alt_r[`PIN_EXP_IRQ0] |=> gpio_oe_n_r[`PIN_EXP_IRQ0]) // R13
        else $error("alternate input pin is being driven");
    port2_reset_a: assert property (alt_r[0] && port_rst_r[0] |=> !gpio_out_r[0] && !gpio_oe_n_r[0]) // R5
        else $error("port 2 reset not driven low");
    port4_reset_a: assert property (alt_r[1] && !port_rst_r[1] && fundamental_reset_n
                                    |=> gpio_out_r[1] && !gpio_oe_n_r[1]) // R6
        else $error("port 4 reset not released high");
    irq_route_a: assert property (alt_r[3] && !gpio_in[3] |=> !expander_irq_n_r[1]) // R7
        else $error("expander interrupt 1 not routed");
    slave_addr_a: assert property (capture |=> slave_bus_addr_r == {2'b11, $past(slave_bus_addr_strap[3]),
                                   1'b0, $past(slave_bus_addr_strap[2:0])}) // R9
        else $error("slave address wrong after capture");
    master_addr_a: assert property (capture |=> master_bus_addr_r == {3'b101, $past(master_bus_addr_strap)}) // R8
        else $error("master address wrong after capture");
    ref_select_a: assert property (capture && ref_clock_freq_select |=> pll_fbdiv_r == `PLL_FBDIV_125) // R2
        else $error("125 MHz reference not selected");
    cfg_default_a: assert property (!fundamental_reset_n |=> alt_r == '0 && dir_r == '0) // R14
        else $error("pin configuration not at default");
    gpio_input_a: assert property (!dir_r[5] |=> gpio_oe_n_r[5]) // R4
        else $error("gpio input pin is being driven");
    bus_pull_a: assert property (master_data_pull |=> !master_bus_data_line_oe_n ##1 1'b1) // R10
        else $error("bus data line not pulled low");
    straps_hold_a: assert property (!capture && !rst |=> $stable(slave_bus_addr_r)) // R11
        else $error("slave address changed without capture");

endmodule
`default_nettype wire

/* sim/pin_board_model.sv */
// board around the pin mux: gpio pull-ups, hot-plug expander and the bus lines
// assumes: pins resolved each cycle; the expander answers a read request after a short wait
`timescale 1ns/1ps
`default_nettype none
module pin_board_model
    import pin_mux_pkg::*;
#(
    parameter int GPIO_W = 11
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // gpio pins
    input  wire logic [GPIO_W-1:0] pin_out,
    input  wire logic [GPIO_W-1:0] pin_oe_n,
    input  wire logic [GPIO_W-1:0] board_level,
    output var  logic [GPIO_W-1:0] pin_level,
    // expander
    input  wire logic [2:0]        irq_on,
    input  wire logic              read_req,
    output var  logic              read_ack,
    // open drain bus lines, index 0 mclk, 1 mdat, 2 sclk, 3 sdat
    input  wire logic [3:0]        line_out,
    input  wire logic [3:0]        line_oe_n,
    output var  logic [3:0]        line_level
);
    logic [GPIO_W-1:0] far;
    logic [1:0]        wait_cnt;

    always_comb
    begin
        far      = board_level;
        far[4:2] = board_level[4:2] & ~irq_on;
        pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & far);
    end

    // released lines float up through the board pull-ups
    assign line_level = line_oe_n | line_out;

    always @(posedge clock)
    begin
        if (rst || !read_req || read_ack)
        begin
            wait_cnt <= 2'h0;
            read_ack <= 1'b0;
        end
        else if (wait_cnt == 2'h2)
        begin
            read_ack <= 1'b1;
            wait_cnt <= 2'h0;
        end
        else
        begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

/* sim/switch_pin_function_mux_test.sv */
// self-checking bench for the pin function mux, apb tasks and pin checks
// assumes: pin_board_model stands on the pin side and returns gpio_in, the bus line levels and read_ack; all other inputs driven from here
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"
module switch_pin_function_mux_test
    import pin_mux_pkg::*;
;
    localparam int W = 11;
    logic          clock;
    logic          rst;
    apb_req_s      apb_in;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    logic          frst_n;
    logic          refsel;
    logic [3:0]    mstrap;
    logic [3:0]    sstrap;
    logic [5:0]    pll_fbdiv_r;
    logic [6:0]    maddr_r;
    logic [6:0]    saddr_r;
    logic [W-1:0]  gpio_in;
    logic [W-1:0]  gpio_out_r;
    logic [W-1:0]  gpio_oe_n_r;
    logic [W-1:0]  board;
    logic [2:0]    irq_n_r;
    logic [2:0]    irq_on;
    logic          read_req;
    logic          read_ack;
    logic [3:0]    pull;
    logic [3:0]    line_in;
    logic [3:0]    line_out;
    logic [3:0]    line_oe_n;
    logic [3:0]    levels;
    logic [31:0]   rd;
    logic          er;
    logic [6:0]    m;
    logic [6:0]    s;
    int            fail_count;
    int            checks;
    int            cycles;
    int            n;

    switch_pin_function_mux #(.GPIO_W(W)) dut (
        .clock(clock), .rst(rst), .apb_in(apb_in), .prdata_r(prdata_r), .pready_r(pready_r),
        .pslverr_r(pslverr_r), .fundamental_reset_n(frst_n), .ref_clock_freq_select(refsel),
        .master_bus_addr_strap(mstrap), .slave_bus_addr_strap(sstrap), .pll_fbdiv_r(pll_fbdiv_r),
        .master_bus_addr_r(maddr_r), .slave_bus_addr_r(saddr_r), .gpio_in(gpio_in),
        .gpio_out_r(gpio_out_r), .gpio_oe_n_r(gpio_oe_n_r), .expander_irq_n_r(irq_n_r),
        .expander_read_req_r(read_req), .expander_read_ack(read_ack),
        .master_clock_pull(pull[0]), .master_data_pull(pull[1]),
        .slave_clock_pull(pull[2]), .slave_data_pull(pull[3]),
        .master_bus_clock_line_in(line_in[0]), .master_bus_clock_line_out(line_out[0]),
        .master_bus_clock_line_oe_n(line_oe_n[0]), .master_bus_data_line_in(line_in[1]),
        .master_bus_data_line_out(line_out[1]), .master_bus_data_line_oe_n(line_oe_n[1]),
        .slave_bus_clock_line_in(line_in[2]), .slave_bus_clock_line_out(line_out[2]),
        .slave_bus_clock_line_oe_n(line_oe_n[2]), .slave_bus_data_line_in(line_in[3]),
        .slave_bus_data_line_out(line_out[3]), .slave_bus_data_line_oe_n(line_oe_n[3]),
        .bus_line_level_r(levels));

    pin_board_model #(.GPIO_W(W)) board_model (
        .clock(clock), .rst(rst), .pin_out(gpio_out_r), .pin_oe_n(gpio_oe_n_r),
        .board_level(board), .pin_level(gpio_in), .irq_on(irq_on), .read_req(read_req),
        .read_ack(read_ack), .line_out(line_out), .line_oe_n(line_oe_n), .line_level(line_in));

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apb_in.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready_r !== 1'b1);
        rd = prdata_r;
        er = pslverr_r;
        apb_in <= '0;
        check_word(32'(n), 32'h2, "apb answer");
    endtask

    task settle(input int c);
        repeat (c) @(posedge clock);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            report_and_stop;
        end
    end

    initial
    begin
        rst = 1'b1; apb_in = '0; frst_n = 1'b1; refsel = 1'b0; mstrap = 4'h0; sstrap = 4'h0;
        board = '1; irq_on = 3'h0; pull = 4'h0; fail_count = 0; checks = 0; cycles = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        settle(3);
        check_word(32'(gpio_oe_n_r), 32'h7FF, "oe after reset");
        check_word(32'(pll_fbdiv_r), 32'(`PLL_FBDIV_100), "fbdiv after reset");
        apb(1'b0, `ADDR_GPIO_ALT, 32'h0);
        check_word(rd, 32'h0, "alt after reset");
        apb(1'b0, `ADDR_GPIO_DIR, 32'h0);
        check_word(rd, 32'h0, "dir after reset");
        $display("test reset done");

        board <= 11'h015;
        apb(1'b1, `ADDR_GPIO_DIR, 32'h7E0);
        apb(1'b1, `ADDR_GPIO_OUT, 32'h2A0);
        settle(3);
        check_word(32'(gpio_oe_n_r), 32'h01F, "gpio oe");
        check_word(32'(gpio_out_r), 32'h2A0, "gpio out");
        apb(1'b0, `ADDR_GPIO_IN, 32'h0);
        check_word(rd, 32'h2B5, "gpio in");
        $display("test gpio done");

        board <= '1;
        apb(1'b1, `ADDR_GPIO_ALT, 32'h7FF);
        apb(1'b0, `ADDR_GPIO_ALT, 32'h0);
        check_word(rd, 32'h01F, "alt mask");
        apb(1'b1, `ADDR_GPIO_DIR, 32'h7FF);
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, `ADDR_PORT_RST, 32'(p));
            settle(2);
            check_word(32'(gpio_oe_n_r), 32'h01C, "alt direction");
            check_word(32'(gpio_out_r[1:0]), {30'h0, ~p[1:0]}, "port resets");
        end
        $display("test alternate done");

        for (int k = 0; k < 3; k++)
        begin
            irq_on <= 3'h1 << k;
            settle(3);
            check_word(32'(irq_n_r), {29'h0, ~(3'h1 << k)}, "irq level");
            check_word(32'(read_req), 32'h1, "read request");
            apb(1'b0, `ADDR_EXP_STAT, 32'h0);
            check_word(32'(rd[2:0]), 32'(3'h1 << k), "irq status");
            irq_on <= 3'h0;
            settle(1);
            n = 0;
            while (read_req !== 1'b0 && n < 20)
            begin
                @(posedge clock);
                n++;
            end
            check_word(32'(read_req), 32'h0, "request cleared");
        end
        $display("test expander done");

        for (int i = 0; i < 2; i++)
        begin
            mstrap <= (i == 0) ? 4'h5 : 4'hA;
            sstrap <= (i == 0) ? 4'h6 : 4'h9;
            refsel <= i[0];
            frst_n <= 1'b0;
            settle(3);
            frst_n <= 1'b1;
            settle(3);
            m = {3'b101, mstrap};
            s = {2'b11, sstrap[3], 1'b0, sstrap[2:0]};
            check_word(32'(maddr_r), 32'(m), "master addr");
            check_word(32'(saddr_r), 32'(s), "slave addr");
            check_word(32'(pll_fbdiv_r), (i == 0) ? 32'h19 : 32'h14, "fbdiv");
            apb(1'b0, `ADDR_STRAP, 32'h0);
            check_word(rd, {15'h0, refsel, 1'b0, m, 1'b0, s}, "strap reg");
            check_word(32'(gpio_oe_n_r), 32'h7FF, "oe cleared");
            apb(1'b0, `ADDR_GPIO_ALT, 32'h0);
            check_word(rd, 32'h0, "alt cleared");
        end
        irq_on <= 3'h7;
        settle(3);
        check_word(32'(irq_n_r), 32'h7, "irq gated off");
        irq_on <= 3'h0;
        apb(1'b1, `ADDR_STRAP, 32'hFFFFFFFF);
        apb(1'b0, `ADDR_STRAP, 32'h0);
        check_word(rd, {15'h0, refsel, 1'b0, m, 1'b0, s}, "strap read only");
        $display("test straps done");

        for (int i = 0; i < 5; i++)
        begin
            pull <= (i < 4) ? (4'h1 << i) : 4'h0;
            settle(3);
            check_word(32'(levels), {28'h0, ~pull}, "line levels");
            check_word(32'(line_oe_n), {28'h0, ~pull}, "line drive");
        end
        $display("test bus lines done");

        apb(1'b0, 8'h1C, 32'h0);
        check_word({31'h0, er}, 32'h1, "unmapped error");
        check_word(rd, 32'h0, "unmapped data");
        $display("test unmapped done");
        report_and_stop;
    end
endmodule
`default_nettype wire
